//--- logic/acr_regs.sv
/*
 * Converter configuration registers with APB slave, result holding
 * register, ready flag and interrupt logic.
 * Assumes conv_done is a one-cycle pulse on ref_clk from the
 * converter core, with conv_result valid in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module acr_regs
    import acr_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    resetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ACR_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    conv_done,
    input  wire logic [ACR_RESULT_W-1:0] conv_result,
    output acr_ctrl_t                    ctrl,
    output logic                         mod_clk_turbo,
    output logic      [ACR_RATE_W-1:0]   rate_sps,
    output logic      [ACR_CUR_W-1:0]    excitation_ua,
    output logic                         irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    acr_setup_t                setup_q;
    acr_outexc_t               outexc_q;
    logic                      ready_q;
    logic [ACR_EVT_W-1:0]      status_q;
    logic [ACR_EVT_W-1:0]      mask_q;
    logic [ACR_RESULT_W-1:0]   result_q;
    logic [31:0]               prdata_q;
    logic                      pslverr_q;
    logic                      rd_ok_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic       setup_ph  = psel && !penable;
    wire logic       access    = psel && penable;
    wire logic       aligned   = (paddr[1:0] == 2'b00);
    wire logic [7:0] idx       = 8'(paddr[ACR_ADDR_W-1:2]);
    wire logic       hit_setup = aligned && (idx == ACR_IDX_SETUP);
    wire logic       hit_outex = aligned && (idx == ACR_IDX_OUTEXC);
    wire logic       hit_stat  = aligned && (idx == ACR_IDX_STATUS);
    wire logic       hit_mask  = aligned && (idx == ACR_IDX_MASK);
    wire logic       hit_res   = aligned && (idx == ACR_IDX_RESULT);
    wire logic       hit_rate  = aligned && (idx == ACR_IDX_RATE);
    wire logic       mapped    = hit_setup || hit_outex || hit_stat ||
                                 hit_mask || hit_res || hit_rate;
    wire logic       wr        = access && pwrite && mapped;
    // A result landing in the setup cycle is not the one being read
    wire logic       rd_res    = access && !pwrite && hit_res && rd_ok_q;

    wire acr_outexc_t outexc_rd = '{
        result_ready_flag:        ready_q,
        sample_counter_enable:    outexc_q.sample_counter_enable,
        check_select:             outexc_q.check_select,
        burnout_source_enable:    outexc_q.burnout_source_enable,
        excitation_current_level: outexc_q.excitation_current_level};

    wire logic [31:0] rd_mux =
        hit_setup ? {24'h000000, setup_q} :
        hit_outex ? {24'h000000, outexc_rd} :
        hit_stat  ? {30'h0, status_q} :
        hit_mask  ? {30'h0, mask_q} :
        hit_res   ? {8'h00, result_q} :
        hit_rate  ? {20'h00000, rate_sps} : 32'h00000000;

    // ------------------------------------------------------------
    // Ready flag and events
    // ------------------------------------------------------------
    // A new result in the cycle the old one is read keeps the flag set
    wire logic ready_d = conv_done ? 1'b1 : (rd_res ? 1'b0 : ready_q);
    wire logic [ACR_EVT_W-1:0] evt = {conv_done && ready_q && !rd_res,
                                      conv_done};
    wire logic [ACR_EVT_W-1:0] w1c = (wr && hit_stat) ?
                                     pwdata[ACR_EVT_W-1:0] : '0;
    wire logic [ACR_EVT_W-1:0] status_d = evt | (status_q & ~w1c);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            setup_q  <= acr_setup_t'(ACR_SETUP_RST);
            outexc_q <= acr_outexc_t'(ACR_OUTEXC_RST);
            ready_q  <= 1'b0;
            status_q <= '0;
            mask_q   <= '0;
            result_q <= '0;
        end else begin
            if (wr && hit_setup)
                setup_q <= acr_setup_t'(pwdata[7:0]);
            // Ready bit is read-only; writes leave its storage clear
            if (wr && hit_outex)
                outexc_q <= acr_outexc_t'({1'b0, pwdata[6:0]});
            if (wr && hit_mask)
                mask_q <= pwdata[ACR_EVT_W-1:0];
            if (conv_done)
                result_q <= conv_result;
            ready_q  <= ready_d;
            status_q <= status_d;
        end
    end

    // Read data is captured in the setup cycle so prdata is a flop
    // and the access phase still completes with no wait state.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
            rd_ok_q   <= 1'b0;
        end else if (setup_ph) begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= !mapped;
            rd_ok_q   <= !conv_done;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = access;
    assign pslverr = access && pslverr_q;
    assign irq     = |(status_q & mask_q);

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    // Temperature mode forces the internal reference whatever is stored
    assign ctrl = '{
        turbo_select:             setup_q.turbo_select,
        continuous_select:        setup_q.continuous_select,
        ref_select:               setup_q.temp_sensor_enable ?
                                  ACR_REF_INT : setup_q.ref_select,
        temp_sensor_enable:       setup_q.temp_sensor_enable,
        ignore_input_setup:       setup_q.temp_sensor_enable,
        sample_counter_enable:    outexc_q.sample_counter_enable,
        check_select:             outexc_q.check_select,
        burnout_source_enable:    outexc_q.burnout_source_enable,
        excitation_current_level: outexc_q.excitation_current_level};
    assign mod_clk_turbo = setup_q.turbo_select;

    // Reserved codes are left to the host to avoid; stored as written
    acr_rate_lut u_lut (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .rate_code  (setup_q.rate_select),
        .turbo      (setup_q.turbo_select),
        .cur_code   (outexc_q.excitation_current_level),
        .rate_sps_q (rate_sps),
        .cur_ua_q   (excitation_ua)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ready_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        conv_done |=> ready_q && status_q[ACR_EVT_READY])
        else $error("ready flag not set after result");
    ready_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (rd_res && !conv_done) |=> !ready_q)
        else $error("ready flag not cleared by result read");
    setup_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wr && hit_setup) |=> (setup_q == $past(pwdata[7:0])))
        else $error("setup register write lost");
    ready_ro_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wr && hit_outex && !conv_done && !ready_q) |=> !ready_q)
        else $error("ready flag written by software");
    temp_ref_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        setup_q.temp_sensor_enable |-> (ctrl.ref_select == ACR_REF_INT)
            && ctrl.ignore_input_setup)
        else $error("temperature mode not on internal reference");
    ref_pass_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !setup_q.temp_sensor_enable |-> (ctrl.ref_select == setup_q.ref_select))
        else $error("reference code not passed through");
    reset_zero_a: assert property (@(posedge ref_clk)
        !resetn |=> (setup_q == 8'h00) && (outexc_rd == 8'h00))
        else $error("registers not zero after reset");
    outexc_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wr && hit_outex) |=> (ctrl.check_select == $past(pwdata[5:4]))
            && (ctrl.burnout_source_enable == $past(pwdata[3])))
        else $error("output setup write not applied");
    turbo_clk_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wr && hit_setup) |=> (mod_clk_turbo == $past(pwdata[4])))
        else $error("modulator clock select mismatch");
    err_unmapped_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (setup_ph && !mapped) |=> pslverr)
        else $error("unmapped address not flagged");

endmodule : acr_regs
`default_nettype wire

//--- logic/acr_pkg.sv
/*
 * Constants, field layouts and carrier types for the converter
 * configuration register block.
 * Assumes a single 125 MHz clock domain and a 32-bit APB master.
 */
// Functional notes
// - Normal mode rate codes give 20..1000 SPS
// - Turbo mode rate codes give 40..2000 SPS
// - Mode bit selects 256 or 512 kHz modulator
// - Conversion bit selects single-shot or continuous
// - Reference code: internal, external, supply, supply
// - Temperature mode ignores register 0, internal reference
// - Ready flag set on result, cleared on read
// - Counter enable bit, default off
// - Integrity check: off, inverted copy, CRC16, reserved
// - Burn-out sources follow their bit, default off
// - Excitation magnitude code: off, 10..1500 microamps
// - Registers at 01h and 02h, reset zero
package acr_pkg;

    // ------------------------------------------------------------
    // Register indices and APB address width
    // ------------------------------------------------------------
    localparam logic [7:0] ACR_IDX_SETUP   = 8'h01;
    localparam logic [7:0] ACR_IDX_OUTEXC  = 8'h02;
    localparam logic [7:0] ACR_IDX_STATUS  = 8'h03;
    localparam logic [7:0] ACR_IDX_MASK    = 8'h04;
    localparam logic [7:0] ACR_IDX_RESULT  = 8'h05;
    localparam logic [7:0] ACR_IDX_RATE    = 8'h06;
    localparam int         ACR_ADDR_W      = 12;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] ACR_SETUP_RST   = 8'h00;
    localparam logic [7:0] ACR_OUTEXC_RST  = 8'h00;
    localparam int         ACR_READY_BIT   = 7;
    localparam int         ACR_EVT_READY   = 0;
    localparam int         ACR_EVT_OVERRUN = 1;
    localparam int         ACR_EVT_W       = 2;
    localparam int         ACR_RESULT_W    = 24;
    localparam int         ACR_RATE_W      = 12;
    localparam int         ACR_CUR_W       = 11;

    localparam logic [2:0] ACR_RATE_RSVD   = 3'h7;
    localparam logic [1:0] ACR_REF_INT     = 2'h0;
    localparam logic [1:0] ACR_CHK_RSVD    = 2'h3;
    localparam int         ACR_MOD_KHZ_NORMAL = 256;
    localparam int         ACR_MOD_KHZ_TURBO  = 512;

    // Rates in SPS for codes 0..6; reserved code 7 has no entry
    localparam logic [11:0] ACR_RATE_NORMAL [7] = '{
        12'h014, 12'h02D, 12'h05A, 12'h0AF, 12'h14A, 12'h258, 12'h3E8};
    localparam logic [11:0] ACR_RATE_TURBO  [7] = '{
        12'h028, 12'h05A, 12'h0B4, 12'h15E, 12'h294, 12'h4B0, 12'h7D0};
    localparam logic [10:0] ACR_CUR_UA [8] = '{
        11'h000, 11'h00A, 11'h032, 11'h064, 11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC};

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rate_select;
        logic       turbo_select;
        logic       continuous_select;
        logic [1:0] ref_select;
        logic       temp_sensor_enable;
    } acr_setup_t;

    typedef struct packed {
        logic       result_ready_flag;
        logic       sample_counter_enable;
        logic [1:0] check_select;
        logic       burnout_source_enable;
        logic [2:0] excitation_current_level;
    } acr_outexc_t;

    typedef struct packed {
        logic       turbo_select;
        logic       continuous_select;
        logic [1:0] ref_select;
        logic       temp_sensor_enable;
        logic       ignore_input_setup;
        logic       sample_counter_enable;
        logic [1:0] check_select;
        logic       burnout_source_enable;
        logic [2:0] excitation_current_level;
    } acr_ctrl_t;

endpackage : acr_pkg

//--- logic/acr_rate_lut.sv
/*
 * Lookup of output sample rate and excitation magnitude from the
 * configuration codes. Outputs are registered, one cycle behind.
 * Assumes codes come from registers on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module acr_rate_lut
    import acr_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic [2:0]           rate_code,
    input  wire logic                 turbo,
    input  wire logic [2:0]           cur_code,
    output logic      [ACR_RATE_W-1:0] rate_sps_q,
    output logic      [ACR_CUR_W-1:0]  cur_ua_q
);
    // ------------------------------------------------------------
    // Table selection
    // ------------------------------------------------------------
    // Reserved code is steered off the seven-entry tables before lookup
    wire logic [2:0]            rate_idx   = (rate_code == ACR_RATE_RSVD) ? 3'h0 : rate_code;
    wire logic [ACR_RATE_W-1:0] rate_norm  = ACR_RATE_NORMAL[rate_idx];
    wire logic [ACR_RATE_W-1:0] rate_turbo = ACR_RATE_TURBO[rate_idx];
    // Reserved code reads as zero rate so it cannot be mistaken
    wire logic [ACR_RATE_W-1:0] rate_d =
        (rate_code == ACR_RATE_RSVD) ? '0 :
        turbo ? rate_turbo : rate_norm;
    wire logic [ACR_CUR_W-1:0]  cur_d = ACR_CUR_UA[cur_code];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rate_sps_q <= '0;
            cur_ua_q   <= '0;
        end else begin
            rate_sps_q <= rate_d;
            cur_ua_q   <= cur_d;
        end
    end

    rate_normal_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!turbo && rate_code == 3'h6) |=> (rate_sps_q == 12'h3E8))
        else $error("normal rate code 6 not 1000 SPS");
    rate_turbo_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (turbo && rate_code == 3'h0) |=> (rate_sps_q == 12'h028))
        else $error("turbo rate code 0 not 40 SPS");
    cur_max_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cur_code == 3'h7) |=> (cur_ua_q == 11'h5DC))
        else $error("excitation code 7 not 1500 uA");

endmodule : acr_rate_lut
`default_nettype wire

//--- bench/acr_core_model.sv
/*
 * Behavioural converter core: one-cycle done pulse with a 24-bit result,
 * on request or back to back while continuous mode is selected.
 * Assumes the same clock and synchronous reset as the register block.
 */
`timescale 1ns/100ps
`default_nettype none
module acr_core_model #(
    parameter int GAP = 6
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        start,
    input  wire logic        continuous,
    output logic             conv_done,
    output logic [23:0]      conv_result
);
    logic        busy_q;
    logic [7:0]  cnt_q;
    logic [23:0] val_q;

    // Off the pulse the lines show the inverse, so a late sample is caught
    assign conv_result = conv_done ? val_q : ~val_q;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            busy_q    <= 1'b0;
            cnt_q     <= 8'h00;
            val_q     <= 24'h5A5A5A;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (!busy_q && (start || continuous)) begin
                busy_q <= 1'b1;
                cnt_q  <= 8'h00;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == 8'(GAP - 1)) begin
                    busy_q    <= 1'b0;
                    conv_done <= 1'b1;
                    val_q     <= {val_q[22:0], val_q[23] ^ val_q[22] ^ val_q[21] ^ val_q[16]};
                end
            end
        end
    end
endmodule : acr_core_model
`default_nettype wire

//--- bench/acr_regs_test.sv
/*
 * Self-checking bench for the configuration register block.
 * Assumes acr_pkg and the core model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module acr_regs_test
    import acr_pkg::*;
;
    logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        conv_done, start, irq, mod_clk_turbo, err;
    logic [11:0] paddr, rate_sps;
    logic [31:0] pwdata, prdata, v, lfsr_q;
    logic [23:0] conv_result, res_exp;
    logic [10:0] excitation_ua;
    logic [7:0]  s;
    acr_ctrl_t   ctrl;
    int          error_cnt, cmp_count;

    acr_regs i_acr_regs (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done), .conv_result(conv_result), .ctrl(ctrl),
        .mod_clk_turbo(mod_clk_turbo), .rate_sps(rate_sps), .excitation_ua(excitation_ua),
        .irq(irq));
    acr_core_model #(.GAP(6)) i_acr_core_model (.ref_clk(ref_clk), .resetn(resetn),
        .start(start), .continuous(ctrl.continuous_select), .conv_done(conv_done),
        .conv_result(conv_result));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
        return lfsr_q;
    endfunction : rnd

    function automatic logic [31:0] rate_exp(input logic [2:0] c, input logic t);
        logic [11:0] n [8] = '{12'h014, 12'h02D, 12'h05A, 12'h0AF, 12'h14A, 12'h258, 12'h3E8, 12'h000};
        return t ? 32'(n[c]) * 32'h2 : 32'(n[c]); // Turbo doubles each normal rate
    endfunction : rate_exp

    function automatic logic [31:0] cur_exp(input logic [2:0] c);
        logic [10:0] n [8] = '{11'h000, 11'h00A, 11'h032, 11'h064, 11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC};
        return 32'(n[c]);
    endfunction : cur_exp

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer, then an idle cycle so strobes never toggle twice
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r   = prdata;
        err = pslverr;
        if (n >= 20) begin
            error_cnt++;
            test_done();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic conv_wait();
        int n;
        n = 0;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (conv_done !== 1'b1 && n < 50);
        res_exp = conv_result;
        if (n >= 50) begin
            error_cnt++;
            test_done();
        end
        @(posedge ref_clk);
    endtask : conv_wait

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        test_done();
    end

    initial begin
        {resetn, psel, penable, pwrite, start} = 5'h00;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        lfsr_q    = 32'hACA2F1AE;
        error_cnt = 0;
        cmp_count = 0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("rate_sps", 32'(rate_sps), 32'h014);
        apb(1'b0, 12'h004, 32'h0, v);
        chk("setup reset", v, 32'h0);
        apb(1'b0, 12'h008, 32'h0, v);
        chk("outexc reset", v, 32'h0);
        $display("Test reset done");
        for (int m = 0; m < 16; m++) begin
            s = {(m[2:0] == 3'h7) ? 3'h6 : m[2:0], m[3], 4'h0};
            apb(1'b1, 12'h004, {24'h0, s}, v);
            @(posedge ref_clk);
            chk("rate_sps", 32'(rate_sps), rate_exp(s[7:5], s[4]));
            chk("mod_clk_turbo", 32'(mod_clk_turbo), 32'(s[4]));
            apb(1'b0, 12'h018, 32'h0, v);
            chk("rate register", v, rate_exp(s[7:5], s[4]));
        end
        $display("Test rates done");
        for (int c = 0; c < 8; c++) begin
            v = rnd();
            // Reserved check code is never written
            s = {v[7:6], (v[5:4] == 2'h3) ? 2'h1 : v[5:4], v[3], c[2:0]};
            apb(1'b1, 12'h008, {24'h0, s}, v);
            apb(1'b0, 12'h008, 32'h0, v);
            chk("outexc readback", v, {25'h0, s[6:0]});
            chk("excitation_ua", 32'(excitation_ua), cur_exp(c[2:0]));
            chk("counter enable", 32'(ctrl.sample_counter_enable), 32'(s[6]));
            chk("check_select", 32'(ctrl.check_select), 32'(s[5:4]));
            chk("burnout", 32'(ctrl.burnout_source_enable), 32'(s[3]));
        end
        $display("Test output setup done");
        repeat (12) begin
            v = rnd();
            s = {(v[7:5] == 3'h7) ? 3'h6 : v[7:5], v[4:0]};
            apb(1'b1, 12'h004, {24'h0, s}, v);
            apb(1'b0, 12'h004, 32'h0, v);
            chk("setup readback", v, {24'h0, s});
            chk("continuous", 32'(ctrl.continuous_select), 32'(s[3]));
            chk("ref_select", 32'(ctrl.ref_select), s[0] ? 32'h0 : 32'(s[2:1]));
            chk("temp mode", 32'(ctrl.ignore_input_setup), 32'(s[0]));
            chk("temp enable", 32'(ctrl.temp_sensor_enable), 32'(s[0]));
            chk("turbo", 32'(ctrl.turbo_select), 32'(s[4]));
        end
        apb(1'b1, 12'h004, 32'h0, v);
        repeat (10) @(posedge ref_clk);
        apb(1'b0, 12'h014, 32'h0, v);
        apb(1'b1, 12'h00C, 32'h3, v);
        $display("Test conversion setup done");
        apb(1'b1, 12'h010, 32'h1, v);
        conv_wait();
        chk("irq raised", 32'(irq), 32'h1);
        apb(1'b0, 12'h008, 32'h0, v);
        chk("ready set", 32'(v[7]), 32'h1);
        apb(1'b0, 12'h014, 32'h0, v);
        chk("result", v, 32'(res_exp));
        chk("mapped error", 32'(err), 32'h0);
        apb(1'b0, 12'h008, 32'h0, v);
        chk("ready cleared", 32'(v[7]), 32'h0);
        apb(1'b1, 12'h00C, 32'h1, v);
        chk("irq cleared", 32'(irq), 32'h0);
        apb(1'b1, 12'h010, 32'h0, v);
        conv_wait();
        conv_wait();
        apb(1'b0, 12'h00C, 32'h0, v);
        chk("status overrun", v, 32'h3);
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, 12'h010, 32'h2, v);
        chk("irq overrun", 32'(irq), 32'h1);
        apb(1'b0, 12'h01C, 32'h0, v);
        chk("unmapped error", 32'(err), 32'h1);
        chk("unmapped data", v, 32'h0);
        $display("Test ready flag done");
        test_done();
    end
endmodule : acr_regs_test
`default_nettype wire
